// [mcs_chip_select.sv]
/*
 * Midrange and upper peripheral chip select decoder with its
 * configuration registers. Assumes a processor bus that presents a
 * 20-bit address with a valid strobe for one cycle per bus cycle,
 * an early select phase and a multiplexed phase one cycle later.
 */
// Added by the designer: the strobed register port.
// Functional notes
// RQ1: Block size code sets midrange total size; four equal selects.
// RQ2: Code is one-hot: bit0 means 8K total, each bit doubles.
// RQ3: Pin function bit one gives selects, zero gives address a1/a2.
// RQ4: Address mode outputs latched a2 and a1; functions exclusive.
// RQ5: Space bit one: memory cycles only; zero: I/O cycles only.
// RQ6: Aux ready-ignore applies only to upper peripheral selects.
// RQ7: Aux wait field inserts zero to three waits on upper selects.
// RQ8: Upper peripheral pins stay high until configured.
// RQ9: In address mode any aux register access activates the pins.
// RQ10: Midrange selects active only after both registers written.
// RQ11: Midrange selects follow multiplexed bus timing, half cycle later; the code asserts them one full cycle after the upper selects.
// RQ12: Software keeps midrange block out of other select regions.
// RQ13: I/O-mapped peripheral range may overlap midrange without conflict.
// RQ14: Base field gives a19..a13; lower base bits are zero.
// RQ15: Software sets base as multiple of total block size.
// RQ16: Midrange ready-ignore picks ready use; waits still apply.
// RQ17: Midrange wait field inserts zero to three waits.
// RQ18: Exactly one midrange select, chosen by block quarter.
// RQ19: Selects stay off for out-of-range or wrong-type cycles.
`timescale 1ns/1ps
module mcs_chip_select #(
    parameter int ADDR_W = 20
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic bus_start,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic bus_is_mem,
    input wire logic bus_end,
    input wire logic ext_ready,
    output logic [3:0] midrange_selects_n,
    output logic [1:0] upper_periph_selects_n,
    output logic bus_ready
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [15:0] mid_r, mid_nxt;
    logic [15:0] aux_r, aux_nxt;
    logic [15:0] pb_r, pb_nxt;
    logic mid_wr_r, mid_wr_nxt;
    logic aux_wr_r, aux_wr_nxt;
    logic aux_acc_r, aux_acc_nxt;
    logic pb_wr_r, pb_wr_nxt;
    logic [15:0] rdata_nxt;
    logic [15:0] rdata_r;
    logic hit_mid, hit_aux, hit_pb;

    assign hit_mid = (reg_addr == mcs_pkg::MCS_OFF_MIDRANGE);
    assign hit_aux = (reg_addr == mcs_pkg::MCS_OFF_AUX);
    assign hit_pb = (reg_addr == mcs_pkg::MCS_OFF_PERIPH_BASE);

    always_comb begin
        mid_nxt = mid_r;
        aux_nxt = aux_r;
        pb_nxt = pb_r;
        mid_wr_nxt = mid_wr_r;
        aux_wr_nxt = aux_wr_r;
        pb_wr_nxt = pb_wr_r;
        aux_acc_nxt = aux_acc_r;
        rdata_nxt = 16'h0000;
        if (reg_wr && hit_mid) begin
            mid_nxt = reg_wdata | mcs_pkg::MCS_MID_RSV;
            mid_wr_nxt = 1'b1;
        end
        if (reg_wr && hit_aux) begin
            aux_nxt = reg_wdata | mcs_pkg::MCS_AUX_RSV;
            aux_wr_nxt = 1'b1;
        end
        if (reg_wr && hit_pb) begin
            pb_nxt = reg_wdata | mcs_pkg::MCS_PB_RSV;
            pb_wr_nxt = 1'b1;
        end
        // Any access, read or write, counts for address mode. [RQ9]
        if ((reg_wr || reg_rd) && hit_aux) begin
            aux_acc_nxt = 1'b1;
        end
        if (reg_rd) begin
            if (hit_mid) begin
                rdata_nxt = mid_r;
            end else if (hit_aux) begin
                rdata_nxt = aux_r;
            end else if (hit_pb) begin
                rdata_nxt = pb_r;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mid_r <= mcs_pkg::MCS_MID_RSV;
            aux_r <= mcs_pkg::MCS_AUX_RSV;
            pb_r <= mcs_pkg::MCS_PB_RSV;
            mid_wr_r <= 1'b0;
            aux_wr_r <= 1'b0;
            pb_wr_r <= 1'b0;
            aux_acc_r <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            mid_r <= mid_nxt;
            aux_r <= aux_nxt;
            pb_r <= pb_nxt;
            mid_wr_r <= mid_wr_nxt;
            aux_wr_r <= aux_wr_nxt;
            pb_wr_r <= pb_wr_nxt;
            aux_acc_r <= aux_acc_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // Midrange decode
    // ------------------------------------------------------------
    logic [mcs_pkg::MCS_SIZE_W-1:0] size_code;
    logic pin_sel, space_mem;
    logic [ADDR_W-1:0] blk_mask;
    logic [ADDR_W-1:0] blk_base;
    logic [1:0] quarter;
    logic size_ok;
    logic mid_hit;

    assign size_code = aux_r[mcs_pkg::MCS_AUX_SIZE_LSB +:
        mcs_pkg::MCS_SIZE_W];
    assign pin_sel = aux_r[mcs_pkg::MCS_AUX_PINFN];
    assign space_mem = aux_r[mcs_pkg::MCS_AUX_SPACE];
    // Base low bits are zero by construction. [RQ14]
    assign blk_base = {mid_r[15:mcs_pkg::MCS_BASE_LSB],
        {mcs_pkg::MCS_BASE_LSB+4{1'b0}}};

    // One-hot code: bit i gives a block of 2^(13+i) bytes. [RQ2]
    always_comb begin
        blk_mask = '0;
        quarter = 2'h0;
        size_ok = 1'b0;
        for (int i = 0; i < mcs_pkg::MCS_SIZE_W; i++) begin
            if (size_code == 7'(1 << i)) begin
                size_ok = 1'b1;
                blk_mask = ADDR_W'((1 << (mcs_pkg::MCS_MIN_BLOCK_LOG2 + i))
                    - 1);
                quarter = bus_addr[mcs_pkg::MCS_MIN_BLOCK_LOG2 + i - 1
                    -: 2]; // [RQ1] [RQ18]
            end
        end
    end

    // A base that is not block-aligned still compares on the upper
    // bits only, so misaligned bases alias down to the aligned block.
    assign mid_hit = size_ok && mid_wr_r && aux_wr_r && bus_is_mem &&
        ((bus_addr & ~blk_mask) == (blk_base & ~blk_mask)); // [RQ10] [RQ19]

    // ------------------------------------------------------------
    // Upper peripheral decode
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] pb_base;
    logic [2:0] pb_idx;
    logic pb_in;
    logic space_ok;
    logic [1:0] up_hit;

    assign pb_base = {pb_r[15:mcs_pkg::MCS_PB_LSB],
        {ADDR_W-9{1'b0}}};
    assign pb_idx = bus_addr[10:8];
    assign pb_in = (bus_addr[ADDR_W-1:11] == pb_base[ADDR_W-1:11]);
    // Selects answer one cycle type only, so I/O overlap is harmless.
    assign space_ok = (bus_is_mem == space_mem); // [RQ5] [RQ13]
    assign up_hit[0] = pb_in && space_ok && pin_sel && pb_wr_r &&
        aux_wr_r && (pb_idx == mcs_pkg::MCS_PCS5_IDX); // [RQ19]
    assign up_hit[1] = pb_in && space_ok && pin_sel && pb_wr_r &&
        aux_wr_r && (pb_idx == mcs_pkg::MCS_PCS6_IDX); // [RQ19]

    // ------------------------------------------------------------
    // Cycle tracking and pins
    // ------------------------------------------------------------
    logic [3:0] mid_sel_r, mid_sel_nxt;
    logic [3:0] mid_q_r, mid_q_nxt;
    logic [1:0] up_sel_r, up_sel_nxt;
    logic [1:0] a21_r, a21_nxt;
    logic active_r, active_nxt;
    logic waiting_r, waiting_nxt;
    mcs_wait_if wif ();

    always_comb begin
        mid_q_nxt = mid_q_r;
        mid_sel_nxt = mid_sel_r;
        up_sel_nxt = up_sel_r;
        a21_nxt = a21_r;
        active_nxt = active_r;
        waiting_nxt = waiting_r;
        wif.start = 1'b0;
        wif.count = 2'h0;
        wif.ign_rdy = 1'b1;
        if (bus_start) begin
            // Upper selects decode early; midrange waits a cycle. [RQ11]
            mid_q_nxt = mid_hit ? (4'h1 << quarter) : 4'h0;
            up_sel_nxt = up_hit;
            // Captured on every start whatever the pin mode, so a switch
            // into address mode first shows the last cycle's bits.
            a21_nxt = {bus_addr[2], bus_addr[1]}; // [RQ4]
            active_nxt = 1'b1;
            mid_sel_nxt = 4'h0;
            if (mid_hit) begin
                wif.start = 1'b1;
                wif.count = mid_r[1:0]; // [RQ17]
                wif.ign_rdy = mid_r[mcs_pkg::MCS_RDY_IGN]; // [RQ16]
                waiting_nxt = 1'b1;
            end else if (up_hit != 2'h0) begin
                wif.start = 1'b1;
                wif.count = aux_r[1:0]; // [RQ7]
                wif.ign_rdy = aux_r[mcs_pkg::MCS_RDY_IGN]; // [RQ6]
                waiting_nxt = 1'b1;
            end
        end else if (active_r) begin
            mid_sel_nxt = mid_q_r; // [RQ11]
        end
        if (wif.done) begin
            waiting_nxt = 1'b0;
        end
        if (bus_end) begin
            mid_sel_nxt = 4'h0;
            mid_q_nxt = 4'h0;
            up_sel_nxt = 2'h0;
            active_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mid_q_r <= 4'h0;
            mid_sel_r <= 4'h0;
            up_sel_r <= 2'h0;
            a21_r <= 2'h0;
            active_r <= 1'b0;
            waiting_r <= 1'b0;
        end else begin
            mid_q_r <= mid_q_nxt;
            mid_sel_r <= mid_sel_nxt;
            up_sel_r <= up_sel_nxt;
            a21_r <= a21_nxt;
            active_r <= active_nxt;
            waiting_r <= waiting_nxt;
        end
    end

    assign wif.ext_rdy = ext_ready;

    // The timer raises done for one cycle only; ready follows it at
    // once so that the bus is not held a cycle longer than programmed.
    mcs_wait_timer mcs_wait_timer_inst (
        .clk_sys(clk_sys),
        .srst(srst),
        .w(wif.tmr)
    );

    assign midrange_selects_n = ~mid_sel_r;
    assign bus_ready = ~waiting_r || wif.done;

    // ------------------------------------------------------------
    // Upper pin register
    // ------------------------------------------------------------
    // The pin value is built from next-state terms so that the pins
    // come straight from a flip-flop without losing a cycle.
    logic [1:0] up_pins_r, up_pins_nxt;
    logic pin_sel_nxt;

    assign pin_sel_nxt = aux_nxt[mcs_pkg::MCS_AUX_PINFN];

    // Pins are either selects or address, never both. [RQ3] [RQ4]
    always_comb begin
        if (pin_sel_nxt && pb_wr_nxt && aux_wr_nxt) begin
            up_pins_nxt = ~up_sel_nxt;
        end else if (!pin_sel_nxt && aux_acc_nxt) begin
            // Only the auxiliary access is needed here. [RQ9]
            up_pins_nxt = {a21_nxt[0], a21_nxt[1]}; // [RQ4]
        end else begin
            up_pins_nxt = 2'b11; // [RQ8]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            up_pins_r <= 2'b11;
        end else begin
            up_pins_r <= up_pins_nxt;
        end
    end

    assign upper_periph_selects_n = up_pins_r;
endmodule : mcs_chip_select

// [mcs_chip_select_sva.sv]
/* Port checker for the chip select block.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module mcs_chip_select_chk (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic bus_start,
    input wire logic bus_is_mem,
    input wire logic bus_end,
    input wire logic [3:0] midrange_selects_n,
    input wire logic [1:0] upper_periph_selects_n,
    input wire logic bus_ready
);
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_mid_reset_off:
        assert property ($fell(srst) |-> midrange_selects_n == 4'hf)
        else $error("midrange select active after reset");
    a_upper_reset_off:
        assert property ($fell(srst) |->
            upper_periph_selects_n == 2'h3 && bus_ready)
        else $error("upper pins or ready wrong after reset");
    a_mid_late_phase:
        assert property (bus_start |=> midrange_selects_n == 4'hf)
        else $error("midrange select asserted in early phase");
    a_mid_io_quiet:
        assert property (bus_start && !bus_is_mem |=>
            (midrange_selects_n == 4'hf)[*3])
        else $error("midrange select on an io cycle");
    a_mid_one_hot:
        assert property ($onehot0(~midrange_selects_n))
        else $error("more than one midrange select active");
    a_sel_hold:
        assert property (midrange_selects_n != 4'hf && !bus_end |=>
            $stable(midrange_selects_n))
        else $error("midrange select changed within a cycle");
    a_sel_drop_end:
        assert property (bus_end |=> midrange_selects_n == 4'hf)
        else $error("midrange select held after bus end");
    a_ready_cause:
        assert property ($fell(bus_ready) |-> $past(bus_start))
        else $error("ready dropped without a bus start");
    c_mid_hit: cover property (midrange_selects_n != 4'hf);
    c_upper_hit: cover property (upper_periph_selects_n != 2'h3);
    c_wait_done: cover property ($rose(bus_ready));
endmodule : mcs_chip_select_chk

bind mcs_chip_select mcs_chip_select_chk mcs_chip_select_chk_inst (
    .clk_sys, .srst, .bus_start, .bus_is_mem, .bus_end,
    .midrange_selects_n, .upper_periph_selects_n, .bus_ready);

// [mcs_chip_select_tb.sv]
/* Self-checking testbench for the chip select block.
   Assumes the package, design, checker and device model. */
`timescale 1ns/1ps
module mcs_chip_select_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic bus_start = 1'b0;
    logic [19:0] bus_addr = 20'h00000;
    logic bus_is_mem = 1'b0;
    logic bus_end = 1'b0;
    logic ext_ready;
    logic [3:0] midrange_selects_n;
    logic [1:0] upper_periph_selects_n;
    logic bus_ready;
    logic [3:0] stall = 4'h6;
    int err_count = 0;
    int n_tests = 0;
    int qs;
    always #10 clk_sys = ~clk_sys;
    mcs_chip_select mcs_chip_select_inst (.clk_sys, .srst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bus_start, .bus_addr,
        .bus_is_mem, .bus_end, .ext_ready, .midrange_selects_n,
        .upper_periph_selects_n, .bus_ready);
    mcs_ext_dev mcs_ext_dev_inst (.clk_sys, .srst, .midrange_selects_n,
        .upper_periph_selects_n, .stall, .ext_ready);
    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("Checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "reg_rdata");
        @(posedge clk_sys);
    endtask : rd
    // Wait check: ew >= 0 exact low cycles, -1 slow, -2 none.
    task automatic bus(input logic [19:0] a, input logic m,
        input logic [3:0] em, input logic [1:0] eu, input int ew);
        int n;
        bus_addr <= a;
        bus_is_mem <= m;
        bus_start <= 1'b1;
        @(posedge clk_sys);
        bus_start <= 1'b0;
        #1 n = int'(bus_ready !== 1'b1);
        @(posedge clk_sys);
        #1 chk({12'h0, midrange_selects_n}, {12'h0, em}, "mid");
        chk({14'h0, upper_periph_selects_n}, {14'h0, eu}, "upper");
        while (bus_ready !== 1'b1 && n < 40) begin
            n++;
            @(posedge clk_sys);
            #1;
        end
        if (n >= 40) begin
            err_count++;
            complete_run();
        end
        if (ew >= 0) chk(16'(n), 16'(ew), "wait");
        if (ew == -1) chk({15'h0, n > 3}, 16'h1, "ready");
        @(posedge clk_sys);
        bus_end <= 1'b1;
        @(posedge clk_sys);
        bus_end <= 1'b0;
    endtask : bus
    // ----------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        bus(20'h80000, 1'b1, 4'hf, 2'h3, 0);
        rd(8'ha0, 16'h0000);
        wr(mcs_pkg::MCS_OFF_PERIPH_BASE, 16'h0000);
        rd(mcs_pkg::MCS_OFF_PERIPH_BASE, mcs_pkg::MCS_PB_RSV);
        wr(mcs_pkg::MCS_OFF_MIDRANGE, 16'h8005);
        rd(mcs_pkg::MCS_OFF_MIDRANGE,
            16'h8005 | mcs_pkg::MCS_MID_RSV);
        bus(20'h80000, 1'b1, 4'hf, 2'h3, 0);
        for (int k = 0; k < 7; k++) begin
            qs = 'h800 << k;
            wr(mcs_pkg::MCS_OFF_AUX, 16'h0084 | (16'h0100 << k));
            wr(mcs_pkg::MCS_OFF_MIDRANGE, 16'h8004 | 16'(k % 4));
            for (int q = 0; q < 4; q++) begin
                bus(20'('h80000 + (q + 1) * qs - 1), 1'b1,
                    ~(4'h1 << q), 2'h3, 1 + k % 4);
            end
            bus(20'('h80000 + 4 * qs), 1'b1, 4'hf, 2'h3, 0);
            bus(20'h7ffff, 1'b1, 4'hf, 2'h3, 0);
        end
        rd(mcs_pkg::MCS_OFF_AUX, 16'h4084 | mcs_pkg::MCS_AUX_RSV);
        wr(mcs_pkg::MCS_OFF_MIDRANGE, 16'h8000);
        bus(20'h80000, 1'b1, 4'he, 2'h3, -1);
        bus(20'h80000, 1'b0, 4'hf, 2'h3, 0);
        wr(mcs_pkg::MCS_OFF_MIDRANGE, 16'h0004);
        for (int w = 0; w < 4; w++) begin
            wr(mcs_pkg::MCS_OFF_AUX, 16'h0184 | 16'(w));
            bus(20'h00500, 1'b0, 4'hf, 2'h2, 1 + w);
        end
        bus(20'h00600, 1'b0, 4'hf, 2'h1, 4);
        bus(20'h00500, 1'b1, 4'he, 2'h3, 1);
        wr(mcs_pkg::MCS_OFF_AUX, 16'h0180);
        bus(20'h00600, 1'b0, 4'hf, 2'h1, -1);
        wr(mcs_pkg::MCS_OFF_MIDRANGE, 16'h8004);
        wr(mcs_pkg::MCS_OFF_AUX, 16'h01c4);
        bus(20'h00600, 1'b1, 4'hf, 2'h1, 1);
        bus(20'h00600, 1'b0, 4'hf, 2'h3, 0);
        // A second reset clears the pin setup before address mode.
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        bus(20'h00002, 1'b0, 4'hf, 2'h3, -2);
        wr(mcs_pkg::MCS_OFF_AUX, 16'h0104);
        bus(20'h00002, 1'b0, 4'hf, 2'h2, -2);
        bus(20'h00004, 1'b1, 4'hf, 2'h1, -2);
        complete_run();
    end
endmodule : mcs_chip_select_tb

// [mcs_ext_dev.sv]
/* Model of the memory and peripheral chips on the selects.
   Assumes active-low selects; stall sets the ready delay. */
`timescale 1ns/1ps
module mcs_ext_dev (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [3:0] midrange_selects_n,
    input wire logic [1:0] upper_periph_selects_n,
    input wire logic [3:0] stall,
    output logic ext_ready
);
    logic sel;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    assign sel = ~&{midrange_selects_n, upper_periph_selects_n};
    // Ready stays low while nothing is selected, so a design that
    // waits for ready on an idle bus hangs and is caught.
    assign ext_ready = sel && (cnt_r >= stall);
    always_comb begin
        cnt_nxt = sel ? cnt_r + {3'h0, cnt_r != 4'hf} : 4'h0;
    end
    always_ff @(posedge clk_sys) begin
        cnt_r <= srst ? 4'h0 : cnt_nxt;
    end
endmodule : mcs_ext_dev

// [mcs_pkg.sv]
/*
 * Package for the midrange and upper peripheral chip select block.
 * Holds register offsets, field positions and timing constants.
 * Assumes a 16-bit register bus with byte offsets as printed.
 */
package mcs_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MCS_OFF_MIDRANGE = 8'ha6;
    localparam logic [7:0] MCS_OFF_AUX = 8'ha8;
    localparam logic [7:0] MCS_OFF_PERIPH_BASE = 8'ha4;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MCS_AUX_SIZE_LSB = 8;
    localparam int MCS_AUX_PINFN = 7;
    localparam int MCS_AUX_SPACE = 6;
    localparam int MCS_RDY_IGN = 2;
    localparam int MCS_BASE_LSB = 9;
    localparam int MCS_SIZE_W = 7;
    // Smallest block is 8K, that is 2^13 bytes.
    localparam int MCS_MIN_BLOCK_LOG2 = 13;
    // Peripheral block: upper selects at base+1280 and base+1536.
    localparam int MCS_PB_LSB = 7;
    localparam logic [2:0] MCS_PCS5_IDX = 3'h5;
    localparam logic [2:0] MCS_PCS6_IDX = 3'h6;
    // Reserved bits read as written ones.
    localparam logic [15:0] MCS_AUX_RSV = 16'h8038;
    localparam logic [15:0] MCS_MID_RSV = 16'h01f8;
    localparam logic [15:0] MCS_PB_RSV = 16'h0070;
    localparam logic [1:0] MCS_WAIT_MAX = 2'h3;
endpackage : mcs_pkg

// [mcs_wait_if.sv]
/*
 * Interface between the decoder and its wait-state timer.
 * Assumes both modules share clk_sys.
 */
`timescale 1ns/1ps
interface mcs_wait_if;
    logic start;
    logic [1:0] count;
    logic ign_rdy;
    logic ext_rdy;
    logic done;
    modport ctl (output start, output count, output ign_rdy,
        output ext_rdy, input done);
    modport tmr (input start, input count, input ign_rdy,
        input ext_rdy, output done);
endinterface : mcs_wait_if

// [mcs_wait_timer.sv]
/*
 * Wait-state timer: counts programmed wait states, then optionally
 * waits for external ready. Assumes start is a one-cycle pulse.
 */
`timescale 1ns/1ps
module mcs_wait_timer (
    input wire logic clk_sys,
    input wire logic srst,
    mcs_wait_if.tmr w
);
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MCS_W_IDLE = 2'b00,
        MCS_W_CNT = 2'b01,
        MCS_W_RDY = 2'b11
    } mcs_wst_t;
    mcs_wst_t st_r, st_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic ign_r, ign_nxt;
    logic done_nxt;
    logic done_r;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ign_nxt = ign_r;
        done_nxt = 1'b0;
        case (st_r)
            MCS_W_IDLE: begin
                if (w.start) begin
                    cnt_nxt = w.count;
                    ign_nxt = w.ign_rdy;
                    st_nxt = MCS_W_CNT;
                end
            end
            MCS_W_CNT: begin
                if (cnt_r != 2'h0) begin
                    cnt_nxt = cnt_r - 2'h1;
                end else if (ign_r || w.ext_rdy) begin
                    done_nxt = 1'b1;
                    st_nxt = MCS_W_IDLE;
                end else begin
                    st_nxt = MCS_W_RDY;
                end
            end
            MCS_W_RDY: begin
                if (w.ext_rdy) begin
                    done_nxt = 1'b1;
                    st_nxt = MCS_W_IDLE;
                end
            end
            default: st_nxt = MCS_W_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r <= MCS_W_IDLE;
            cnt_r <= 2'h0;
            ign_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ign_r <= ign_nxt;
            done_r <= done_nxt;
        end
    end

    assign w.done = done_r;
endmodule : mcs_wait_timer
